// >>> src/flash_seq_regs.svh
/*
  Constants for the flash command sequencer: APB offsets, register bit
  positions, command codes, status bits and array geometry.
  Assumes it is included once per file by its bare name.
*/
`ifndef FLASH_SEQ_REGS_SVH
`define FLASH_SEQ_REGS_SVH

// APB map
`define CTRL_A_OFF      16'h0000
`define CTRL_B_OFF      16'h0004
`define ROM_WIN_BIT     15
`define ROM_WORD_LSB    2
`define ROM_WORD_MSB    11
`define ROM_PAD_LSB     12
`define ROM_PAD_MSB     14

// Control register A bits
`define CA_READY        0
`define CA_OVERRIDE     1
`define CA_FLASH_MODE   2
`define CA_PROG_ERR     6
`define CA_ERASE_ERR    7
// Control register B bits
`define CB_LOCK_STATE   6

// Status byte bits
`define SR_READY        7
`define SR_ERASE_ERR    5
`define SR_PROG_ERR     4

// Command codes (low byte)
`define CMD_READ_ARRAY  8'hFF
`define CMD_READ_STATUS 8'h70
`define CMD_CLR_STATUS  8'h50
`define CMD_PROGRAM     8'h40
`define CMD_BLK_ERASE   8'h20
`define CMD_ERASE_ALL   8'hA7
`define CMD_LOCK_PROG   8'h77
`define CMD_LOCK_READ   8'h71
`define CMD_CONFIRM     8'hD0

// Geometry: 64 words a block, blocks 0..8 plus block A
`define BLK_LSB         6
`define BLK_MSB         9
`define BLK_LAST_ALL    4'h8
`define BLK_A           4'h9
`define ERASED_WORD     16'hFFFF

`endif

// >>> src/flash_seq_pkg.sv
/*
  Types shared by the flash command sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package flash_seq_pkg;

  typedef enum logic [1:0] {
    AK_CTRL_A,
    AK_CTRL_B,
    AK_ROM,
    AK_BAD
  } addr_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SECOND,
    ST_PROG,
    ST_ALL_NEXT,
    ST_ERASE_FILL,
    ST_ERASE_WAIT,
    ST_LOCK_WAIT
  } seq_state_t;

endpackage

// >>> src/flash_word_mem.sv
/*
  Word array of the flash: one write port, one read port whose data
  come from a register one cycle after the address.
  A read of the word written in the same cycle returns its old data.
*/
`timescale 1ns/1ps
module flash_word_mem #(
  parameter int ADDR_W = 10,
  parameter int DATA_W = 16
) (
  input  wire logic              clk,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data
);

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // Array starts erased, as a fresh flash would
  initial begin
    for (int i = 0; i < (1 << ADDR_W); i++) begin
      mem[i] = '1;
    end
  end

  // Write port and registered read
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // flash_word_mem

// >>> src/flash_command_sequencer.sv
/*
  Flash command sequencer: APB slave with two control registers and a
  user-ROM window that takes two-cycle commands, runs program, erase and
  lock-bit operations and switches the read mode.
  Assumes one clock, pclk, and an APB master that keeps to the protocol.
*/
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "flash_seq_regs.svh"
module flash_command_sequencer #(
  parameter int         PROG_CYCLES  = 16,
  parameter int         ERASE_CYCLES = 64,
  parameter int         LOCK_CYCLES  = 8,
  parameter logic [9:0] LOCK_INIT    = 10'h3FF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  localparam int NBLK  = 10;
  localparam int CNT_W = 16;

  // Address decode, used for both reads and writes
  function automatic flash_seq_pkg::addr_kind_t kind_of(input logic [15:0] a);
    if (a[1:0] != 2'h0) begin
      kind_of = flash_seq_pkg::AK_BAD;
    end else if (a[`ROM_WIN_BIT]) begin
      if (a[`ROM_PAD_MSB:`ROM_PAD_LSB] != 3'h0 ||
          a[`ROM_WORD_MSB:`ROM_WORD_LSB+`BLK_LSB] > `BLK_A) begin
        kind_of = flash_seq_pkg::AK_BAD;
      end else begin
        kind_of = flash_seq_pkg::AK_ROM;
      end
    end else if (a == `CTRL_A_OFF) begin
      kind_of = flash_seq_pkg::AK_CTRL_A;
    end else if (a == `CTRL_B_OFF) begin
      kind_of = flash_seq_pkg::AK_CTRL_B;
    end else begin
      kind_of = flash_seq_pkg::AK_BAD;
    end
  endfunction

  flash_seq_pkg::addr_kind_t kind;
  logic [9:0]  word;
  logic [3:0]  blk;
  logic        top_word;
  logic [7:0]  code;
  logic        access;
  logic        wr_rom;
  logic        wr_ctrl_a;

  assign kind     = kind_of(paddr);
  assign word     = paddr[`ROM_WORD_MSB:`ROM_WORD_LSB];
  assign blk      = word[`BLK_MSB:`BLK_LSB];
  assign top_word = &word[`BLK_LSB-1:0];
  assign code     = pwdata[7:0];

  // APB: one wait state on every transfer
  logic ack_reg, ack_next;
  logic err_reg, err_next;
  logic [31:0] rdata_reg, rdata_next;

  assign access  = psel & penable;
  assign pready  = access & ack_reg;
  assign pslverr = pready & err_reg;
  assign prdata  = rdata_reg;
  assign wr_rom    = pready & pwrite & (kind == flash_seq_pkg::AK_ROM);
  assign wr_ctrl_a = pready & pwrite & (kind == flash_seq_pkg::AK_CTRL_A);

  // Sequencer state
  flash_seq_pkg::seq_state_t state_reg, state_next;
  logic [7:0]      pend_reg, pend_next;
  logic [9:0]      op_word_reg, op_word_next;
  logic [15:0]     data_reg, data_next;
  logic [5:0]      ptr_reg, ptr_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic            all_reg, all_next;
  logic            status_mode_reg, status_mode_next;
  logic            perr_reg, perr_next;
  logic            eerr_reg, eerr_next;
  logic            override_reg, override_next;
  logic            flash_mode_reg, flash_mode_next;
  logic            lock_state_reg, lock_state_next;
  logic [NBLK-1:0] lock_reg, lock_next;
  logic            busy;
  logic            ready;
  logic [7:0]      status_byte;

  // Array ports
  logic        mem_we;
  logic [9:0]  mem_waddr;
  logic [15:0] mem_wdata;
  logic [9:0]  mem_raddr;
  logic [15:0] mem_rdata;

  assign busy  = (state_reg != flash_seq_pkg::ST_IDLE) &&
                 (state_reg != flash_seq_pkg::ST_SECOND);
  assign ready = ~busy;

  // Status byte image of the flags
  always_comb begin
    status_byte = 8'h00;
    status_byte[`SR_READY]     = ready;
    status_byte[`SR_ERASE_ERR] = eerr_reg;
    status_byte[`SR_PROG_ERR]  = perr_reg;
  end

  // Read port follows the operation while busy so verify sees old data
  assign mem_raddr = busy ? op_word_reg : word;

  flash_word_mem #(
    .ADDR_W (10),
    .DATA_W (16)
  ) u_mem (
    .clk     (pclk),
    .wr_en   (mem_we),
    .wr_addr (mem_waddr),
    .wr_data (mem_wdata),
    .rd_addr (mem_raddr),
    .rd_data (mem_rdata)
  );

  // APB handshake and read data next values
  always_comb begin
    ack_next   = access & ~ack_reg;
    err_next   = err_reg;
    rdata_next = rdata_reg;
    if (access && !ack_reg) begin
      err_next = (kind == flash_seq_pkg::AK_BAD);
      if (!pwrite) begin
        unique case (kind)
          flash_seq_pkg::AK_CTRL_A: begin
            rdata_next = 32'h0000_0000;
            rdata_next[`CA_READY]      = ready;
            rdata_next[`CA_OVERRIDE]   = override_reg;
            rdata_next[`CA_FLASH_MODE] = flash_mode_reg;
            rdata_next[`CA_PROG_ERR]   = perr_reg;
            rdata_next[`CA_ERASE_ERR]  = eerr_reg;
          end
          flash_seq_pkg::AK_CTRL_B: begin
            rdata_next = 32'h0000_0000;
            rdata_next[`CB_LOCK_STATE] = lock_state_reg;
          end
          flash_seq_pkg::AK_ROM: begin
            // status byte in status mode, else the stored word
            if (status_mode_reg) begin
              rdata_next = {24'h00_0000, status_byte};
            end else begin
              rdata_next = {16'h0000, mem_rdata};
            end
          end
          flash_seq_pkg::AK_BAD: begin
            rdata_next = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // APB registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg   <= 1'b0;
      err_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg   <= ack_next;
      err_reg   <= err_next;
      rdata_reg <= rdata_next;
    end
  end

  // Sequencer next values
  always_comb begin
    state_next       = state_reg;
    pend_next        = pend_reg;
    op_word_next     = op_word_reg;
    data_next        = data_reg;
    ptr_next         = ptr_reg;
    cnt_next         = cnt_reg;
    all_next         = all_reg;
    status_mode_next = status_mode_reg;
    perr_next        = perr_reg;
    eerr_next        = eerr_reg;
    override_next    = override_reg;
    flash_mode_next  = flash_mode_reg;
    lock_state_next  = lock_state_reg;
    lock_next        = lock_reg;
    mem_we           = 1'b0;
    mem_waddr        = op_word_reg;
    mem_wdata        = data_reg;

    if (wr_ctrl_a) begin
      override_next   = pwdata[`CA_OVERRIDE];
      flash_mode_next = pwdata[`CA_FLASH_MODE];
    end

    unique case (state_reg)
      flash_seq_pkg::ST_IDLE: begin
        if (wr_rom) begin
          pend_next    = code;
          op_word_next = word;
          unique case (code)
            `CMD_READ_ARRAY: begin
              status_mode_next = 1'b0;
            end
            `CMD_READ_STATUS: begin
              status_mode_next = 1'b1;
            end
            `CMD_CLR_STATUS: begin
              perr_next = 1'b0;
              eerr_next = 1'b0;
            end
            `CMD_PROGRAM, `CMD_BLK_ERASE, `CMD_ERASE_ALL, `CMD_LOCK_PROG: begin
              if (!perr_reg && !eerr_reg) begin
                state_next = flash_seq_pkg::ST_SECOND;
              end
            end
            `CMD_LOCK_READ: begin
              state_next = flash_seq_pkg::ST_SECOND;
            end
            default: begin
              // Unknown code is a sequence error
              perr_next = 1'b1;
              eerr_next = 1'b1;
            end
          endcase
        end
      end

      flash_seq_pkg::ST_SECOND: begin
        if (wr_rom) begin
          state_next   = flash_seq_pkg::ST_IDLE;
          op_word_next = word;
          data_next    = pwdata[15:0];
          if (pend_reg == `CMD_PROGRAM) begin
            if (word != op_word_reg) begin
              perr_next = 1'b1;
              eerr_next = 1'b1;
            end else if (!lock_reg[blk] && !override_reg) begin
              perr_next = 1'b1;
            end else begin
              cnt_next   = CNT_W'(PROG_CYCLES);
              state_next = flash_seq_pkg::ST_PROG;
              if (!flash_mode_reg) begin
                status_mode_next = 1'b1;
              end
            end
          end else if (code == `CMD_READ_ARRAY) begin
            status_mode_next = 1'b0;
          end else if (code != `CMD_CONFIRM) begin
            perr_next = 1'b1;
            eerr_next = 1'b1;
          end else begin
            unique case (pend_reg)
              `CMD_BLK_ERASE: begin
                // confirm must hit the block top word
                if (!top_word) begin
                  perr_next = 1'b1;
                  eerr_next = 1'b1;
                end else if (!lock_reg[blk] && !override_reg) begin
                  eerr_next = 1'b1;
                end else begin
                  all_next     = 1'b0;
                  ptr_next     = 6'h00;
                  op_word_next = {blk, 6'h00};
                  state_next   = flash_seq_pkg::ST_ERASE_FILL;
                  if (!flash_mode_reg) begin
                    status_mode_next = 1'b1;
                  end
                end
              end
              `CMD_ERASE_ALL: begin
                all_next     = 1'b1;
                op_word_next = 10'h000;
                state_next   = flash_seq_pkg::ST_ALL_NEXT;
                if (!flash_mode_reg) begin
                  status_mode_next = 1'b1;
                end
              end
              `CMD_LOCK_PROG: begin
                // same top address in both cycles
                if (!top_word || word != op_word_reg) begin
                  perr_next = 1'b1;
                  eerr_next = 1'b1;
                end else begin
                  cnt_next   = CNT_W'(LOCK_CYCLES);
                  state_next = flash_seq_pkg::ST_LOCK_WAIT;
                  if (!flash_mode_reg) begin
                    status_mode_next = 1'b1;
                  end
                end
              end
              `CMD_LOCK_READ: begin
                // copy lock bit, short busy period
                lock_state_next  = lock_reg[blk];
                status_mode_next = 1'b0;
                cnt_next         = CNT_W'(LOCK_CYCLES);
                state_next       = flash_seq_pkg::ST_LOCK_WAIT;
              end
              default: begin
                perr_next = 1'b1;
                eerr_next = 1'b1;
              end
            endcase
          end
        end
      end

      flash_seq_pkg::ST_PROG: begin
        cnt_next = cnt_reg - CNT_W'(1);
        if (cnt_reg == CNT_W'(1)) begin
          // Cells only go from 1 to 0; verify catches the rest
          mem_we     = 1'b1;
          mem_wdata  = mem_rdata & data_reg;
          state_next = flash_seq_pkg::ST_IDLE;
          if ((mem_rdata & data_reg) != data_reg) begin
            perr_next = 1'b1;
          end
        end
      end

      flash_seq_pkg::ST_ALL_NEXT: begin
        // blocks 0..8 only, never block A
        if (op_word_reg[`BLK_MSB:`BLK_LSB] > `BLK_LAST_ALL) begin
          state_next = flash_seq_pkg::ST_IDLE;
        end else if (!lock_reg[op_word_reg[`BLK_MSB:`BLK_LSB]] && !override_reg) begin
          op_word_next = op_word_reg + 10'h040;
        end else begin
          ptr_next   = 6'h00;
          state_next = flash_seq_pkg::ST_ERASE_FILL;
        end
      end

      flash_seq_pkg::ST_ERASE_FILL: begin
        // One word cleared to ones per cycle
        mem_we    = 1'b1;
        mem_waddr = {op_word_reg[`BLK_MSB:`BLK_LSB], ptr_reg};
        mem_wdata = `ERASED_WORD;
        ptr_next  = ptr_reg + 6'h01;
        if (&ptr_reg) begin
          cnt_next   = CNT_W'(ERASE_CYCLES);
          state_next = flash_seq_pkg::ST_ERASE_WAIT;
        end
      end

      flash_seq_pkg::ST_ERASE_WAIT: begin
        cnt_next = cnt_reg - CNT_W'(1);
        if (cnt_reg == CNT_W'(1)) begin
          // an erased block comes back unlocked
          lock_next[op_word_reg[`BLK_MSB:`BLK_LSB]] = 1'b1;
          // erase verify always passes here, flag left as is
          if (all_reg) begin
            op_word_next = op_word_reg + 10'h040;
            state_next   = flash_seq_pkg::ST_ALL_NEXT;
          end else begin
            state_next = flash_seq_pkg::ST_IDLE;
          end
        end
      end

      flash_seq_pkg::ST_LOCK_WAIT: begin
        cnt_next = cnt_reg - CNT_W'(1);
        if (cnt_reg == CNT_W'(1)) begin
          if (pend_reg == `CMD_LOCK_PROG) begin
            lock_next[op_word_reg[`BLK_MSB:`BLK_LSB]] = 1'b0;
          end
          state_next = flash_seq_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg       <= flash_seq_pkg::ST_IDLE;
      pend_reg        <= 8'h00;
      op_word_reg     <= 10'h000;
      data_reg        <= 16'hFFFF;
      ptr_reg         <= 6'h00;
      cnt_reg         <= '0;
      all_reg         <= 1'b0;
      status_mode_reg <= 1'b0;
      perr_reg        <= 1'b0;
      eerr_reg        <= 1'b0;
      override_reg    <= 1'b0;
      flash_mode_reg  <= 1'b0;
      lock_state_reg  <= 1'b0;
      lock_reg        <= LOCK_INIT; // Stands in for nonvolatile cells
    end else begin
      state_reg       <= state_next;
      pend_reg        <= pend_next;
      op_word_reg     <= op_word_next;
      data_reg        <= data_next;
      ptr_reg         <= ptr_next;
      cnt_reg         <= cnt_next;
      all_reg         <= all_next;
      status_mode_reg <= status_mode_next;
      perr_reg        <= perr_next;
      eerr_reg        <= eerr_next;
      override_reg    <= override_next;
      flash_mode_reg  <= flash_mode_next;
      lock_state_reg  <= lock_state_next;
      lock_reg        <= lock_next;
    end
  end

endmodule // flash_command_sequencer

// >>> verif/flash_seq_assertions.sv
/*
  Checker for the flash command sequencer: APB timing, status shape,
  error clear and busy after program start.
  Assumes it is bound to the sequencer and sees only its ports.
*/
`timescale 1ns/1ps
`include "flash_seq_regs.svh"
module flash_seq_assertions #(
  parameter int PROG_CYCLES = 16
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  logic [7:0] cmd_reg;
  logic [7:0] cmd_next;
  logic [7:0] age_reg;
  logic [7:0] age_next;
  logic       two_reg;
  logic       two_next;
  logic       rom_wr;
  logic       rd_a;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Completed ROM writes and control register A reads
  assign rom_wr = pready & pwrite & paddr[15] & !pslverr;
  assign rd_a = pready & !pwrite & (paddr == `CTRL_A_OFF);

  // First-cycle code; age since a program start, saturating
  always_comb begin
    cmd_next = cmd_reg;
    two_next = two_reg;
    age_next = (age_reg == 8'hFF) ? age_reg : age_reg + 8'h01;
    if (rom_wr && two_reg) begin
      two_next = 1'b0;
      cmd_next = 8'h00;
      if (cmd_reg == `CMD_PROGRAM) begin
        age_next = 8'h00;
      end
    end else if (rom_wr) begin
      cmd_next = pwdata[7:0];
      two_next = pwdata[7:0] inside {8'h40, 8'h20, 8'hA7, 8'h77, 8'h71};
    end
  end

  // Helper state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg <= 8'h00;
      two_reg <= 1'b0;
      age_reg <= 8'hFF;
    end else begin
      cmd_reg <= cmd_next;
      two_reg <= two_next;
      age_reg <= age_next;
    end
  end

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_one_wait;
    !pready ##1 pready;
  endsequence

  AST_ONE_WAIT: assert property (s_setup ##1 (psel && penable) |-> s_one_wait)
    else $error("access did not take exactly one wait state");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready held for more than one cycle");
  AST_ERR_QUAL: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_ODD_REFUSED: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("unaligned access not refused");
  AST_STATUS_SHAPE: assert property (pready && !pwrite && paddr[15] && !pslverr
    && cmd_reg == `CMD_READ_STATUS |-> prdata[6] == 1'b0 && prdata[3:0] == 4'h0)
    else $error("status byte reserved bits set");
  AST_CLEAR_FLAGS: assert property (rd_a && cmd_reg == `CMD_CLR_STATUS
    |-> prdata[`CA_PROG_ERR] == 1'b0 && prdata[`CA_ERASE_ERR] == 1'b0)
    else $error("error flags not cleared");
  AST_BUSY_AFTER_PROG: assert property (rd_a && age_reg < PROG_CYCLES / 2
    |-> !prdata[`CA_READY])
    else $error("ready flag high during program");
endmodule // flash_seq_assertions

// >>> verif/cpu_bus_model.sv
/*
  CPU-side model: APB master that issues command and data words.
  Assumes pclk from the bench and a slave that answers with pready.
*/
`timescale 1ns/1ps
module cpu_bus_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [15:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0;
  end

  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer taken at the rising edge where pready is sampled high
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines must not show stale values
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // cpu_bus_model

// >>> verif/flash_command_sequencer_tb.sv
/*
  Testbench for the flash command sequencer: command sequences over APB
  with expected values.
  Assumes the CPU model and the checker are compiled alongside.
*/
`timescale 1ns/1ps
`include "flash_seq_regs.svh"
module flash_command_sequencer_tb;
  localparam logic [15:0] CA = `CTRL_A_OFF;
  localparam logic [15:0] CB = `CTRL_B_OFF;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          failures;
  int          checks_done;

  flash_command_sequencer u_flash_command_sequencer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  cpu_bus_model u_cpu_bus_model (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // 25 MHz clock
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  function automatic logic [15:0] rom(input logic [9:0] w);
    return {1'b1, 3'b000, w, 2'b00};
  endfunction
  function automatic logic [15:0] top(input logic [3:0] b);
    return {1'b1, 3'b000, b, 6'h3F, 2'b00};
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      failures++;
      $display("ERROR at %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    u_cpu_bus_model.xfer(1'b1, a, d, r, e);
  endtask
  // ROM reads carry 16 bits only
  task automatic rc(input logic [15:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    u_cpu_bus_model.xfer(1'b0, a, 32'h0, r, e);
    chk(a[15] ? {16'h0, r[15:0]} : r, x);
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic bad(input logic [15:0] a);
    logic [31:0] r;
    logic        e;
    u_cpu_bus_model.xfer(1'b0, a, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
  endtask
  // Poll the ready flag; bounded so a stuck busy is reported
  task automatic wait_rdy();
    logic [31:0] r;
    logic        e;
    int          n;
    n = 0;
    do begin
      u_cpu_bus_model.xfer(1'b0, CA, 32'h0, r, e);
      n++;
    end while (r[`CA_READY] !== 1'b1 && n < 2000);
    chk({31'h0, r[`CA_READY]}, 32'h1);
  endtask
  task automatic two(input logic [15:0] a1, input logic [7:0] c, input logic [15:0] a2);
    wr(a1, {24'h0, c});
    wr(a2, 32'hD0);
  endtask
  task automatic prog(input logic [9:0] w, input logic [15:0] d);
    wr(rom(w), 32'h40);
    wr(rom(w), {16'h0, d});
    wait_rdy();
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog for a hung handshake
  initial begin
    repeat (40000) @(posedge pclk);
    failures++;
    complete_run();
  end

  // Main sequence
  initial begin
    failures = 0;
    checks_done = 0;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rc(CA, 32'h1);
    wr(rom(10'h000), 32'hA5FF);
    rc(rom(10'h005), 32'hFFFF);
    rc(rom(10'h006), 32'hFFFF);
    wr(rom(10'h005), 32'h40);
    wr(rom(10'h005), 32'h1234);
    rc(CA, 32'h0);
    rc(rom(10'h009), 32'h0);
    wait_rdy();
    rc(rom(10'h009), 32'h80);
    wr(rom(10'h000), 32'hFF);
    rc(rom(10'h005), 32'h1234);
    // Ones over zeros: program error
    prog(10'h005, 16'hFFFF);
    rc(CA, 32'h41);
    wr(rom(10'h000), 32'h20);
    wr(top(4'h0), 32'hFF);
    rc(CA, 32'h41);
    rc(rom(10'h005), 32'h1234);
    wr(rom(10'h000), 32'h70);
    rc(rom(10'h000), 32'h90);
    wr(rom(10'h000), 32'h50);
    rc(CA, 32'h1);
    wr(rom(10'h000), 32'h70);
    rc(rom(10'h000), 32'h80);
    // Block erase, status mode held
    two(rom(10'h000), 8'h20, top(4'h0));
    rc(rom(10'h000), 32'h0);
    wait_rdy();
    rc(rom(10'h000), 32'h80);
    wr(rom(10'h000), 32'hFF);
    rc(rom(10'h005), 32'hFFFF);
    rc(CA, 32'h1);
    prog(10'h046, 16'h00AB);
    wr(rom(10'h000), 32'h20);
    wr(top(4'h1), 32'hFF);
    rc(rom(10'h046), 32'h00AB);
    // Lock block 1 and read lock states
    two(top(4'h1), 8'h77, top(4'h1));
    wait_rdy();
    two(rom(10'h000), 8'h71, top(4'h1));
    wait_rdy();
    rc(CB, 32'h0);
    two(rom(10'h000), 8'h71, top(4'h2));
    wait_rdy();
    rc(CB, 32'h40);
    two(rom(10'h000), 8'h20, top(4'h1));
    wait_rdy();
    rc(CA, 32'h81);
    wr(rom(10'h000), 32'hFF);
    rc(rom(10'h046), 32'h00AB);
    wr(rom(10'h000), 32'h50);
    // Override erases a locked block and unlocks it
    wr(CA, 32'h2);
    two(rom(10'h000), 8'h20, top(4'h1));
    wait_rdy();
    rc(CA, 32'h3);
    wr(rom(10'h000), 32'hFF);
    rc(rom(10'h046), 32'hFFFF);
    two(rom(10'h000), 8'h71, top(4'h1));
    wait_rdy();
    rc(CB, 32'h40);
    wr(CA, 32'h0);
    // Erase all skips locked block 2 and block A
    prog(10'h080, 16'h5555);
    prog(10'h200, 16'h0000);
    prog(10'h240, 16'h0F0F);
    two(top(4'h2), 8'h77, top(4'h2));
    wait_rdy();
    two(rom(10'h000), 8'hA7, rom(10'h000));
    wait_rdy();
    wr(rom(10'h000), 32'hFF);
    rc(rom(10'h080), 32'h5555);
    rc(rom(10'h200), 32'hFFFF);
    rc(rom(10'h240), 32'h0F0F);
    rc(CA, 32'h1);
    // Flash-executed mode: program leaves array reads on
    wr(CA, 32'h4);
    prog(10'h010, 16'h1111);
    rc(rom(10'h010), 32'h1111);
    // Unknown code sets both flags, which then refuse an erase
    wr(rom(10'h000), 32'h33);
    rc(CA, 32'hC5);
    two(rom(10'h000), 8'h20, top(4'h0));
    rc(rom(10'h010), 32'h1111);
    wr(rom(10'h000), 32'h50);
    rc(CA, 32'h5);
    wr(CA, 32'h0);
    bad(16'h8002);
    bad(16'h0008);
    complete_run();
  end
endmodule // flash_command_sequencer_tb

bind flash_command_sequencer flash_seq_assertions #(.PROG_CYCLES(PROG_CYCLES))
  u_flash_seq_assertions (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));
